// file: io_function_mapper_test.sv
`timescale 1ns/10ps
module io_function_mapper_test;
    logic aclk = 0, aresetn = 0, fault_present = 0, s_axi_awvalid = 0;
    logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, stop_cmd, fault_trip, disconnect_open;
    logic inline_feedback, bypass_feedback, overload_clear, remote_select;
    logic heat_disable, heat_enable, ramp2_select, slow_fwd_cmd, slow_rev_cmd;
    logic brake_disable, brake_enable, speed_switch, pb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic [3:0] s_axi_wstrb = 4'hf, rb;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, cmd = 0, discrete_input;
    logic [15:0] starter_status = 0, st;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
    logic [5:0] relay_out;
    int err_count = 0, n_tests = 0, seed;
    wire [14:0] fv = {speed_switch, brake_enable, brake_disable, slow_rev_cmd,
        slow_fwd_cmd, ramp2_select, heat_enable, heat_disable, remote_select,
        overload_clear, bypass_feedback, inline_feedback, disconnect_open,
        fault_trip, stop_cmd};
    iofm_mapper #(.TENTH_CYCLES(10)) u_iofm_mapper (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .discrete_input, .starter_status, .fault_present, .stop_cmd,
        .fault_trip, .disconnect_open, .inline_feedback, .bypass_feedback,
        .overload_clear, .remote_select, .heat_disable, .heat_enable,
        .ramp2_select, .slow_fwd_cmd, .slow_rev_cmd, .brake_disable,
        .brake_enable, .speed_switch, .relay_out);
    iofm_field u_iofm_field (.aclk, .contact_cmd(cmd), .discrete_input);
    // 25 MHz clock
    always #20 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rr = s_axi_rresp;
        chk("rdata", e, s_axi_rdata);
        s_axi_rready <= 1'b0;
    endtask
    // Expected function outputs for input 2
    function automatic logic [14:0] di_exp(input logic [4:0] c, input logic p);
        di_exp = '0;
        if (c == 5'h01) di_exp[0] = p;
        if (c >= 5'h05 && c <= 5'h11) di_exp[c-3] = p;
        if (c == 5'h12) di_exp[14] = !p;
    endfunction
    // Expected relay drive
    function automatic logic rl_exp(input logic [4:0] c, input logic [15:0] s,
        input logic f, input logic b);
        case (c)
            5'h00: rl_exp = b;
            5'h01: rl_exp = !f;
            5'h02: rl_exp = f;
            5'h0b: rl_exp = !s[8];
            5'h0c: rl_exp = s[8];
            5'h0d, 5'h0e, 5'h0f: rl_exp = s[c-4];
            5'h10: rl_exp = s[12] | s[13];
            5'h11, 5'h12, 5'h13: rl_exp = s[c-5];
            default: rl_exp = s[c-3];
        endcase
    endfunction
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        finish_test();
    end
    // Main sequence
    initial begin
        seed = $urandom(32'hab9c);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h1);
        rd(8'h0c, 32'h1);
        rd(8'h08, 32'h1);
        chk("relay1", 1, relay_out[0]);
        rd(8'h3c, 0);
        chk("resp", 2, rr);
        wr(8'h3c, 32'h1);
        chk("bresp", 2, br);
        wr(8'h08, 32'h0);
        chk("bresp ok", 0, br);
        rd(8'h08, 32'h1);
        wr(8'h08, 32'h3ff);
        rd(8'h08, 32'h384);
        s_axi_wstrb <= 4'h2;
        wr(8'h00, 32'hffff_ff05);
        s_axi_wstrb <= 4'hf;
        rd(8'h00, 32'h0000_ff01);
        for (int c = 0; c <= 18; c++) begin
            if (c < 2 || c > 4) begin
                pb = $urandom;
                wr(8'h00, {19'h0, c[4:0], 8'h01});
                cmd <= {6'h0, pb, 1'b0};
                starter_status <= $urandom | 16'h8000;
                repeat (6) @(posedge aclk);
                chk("fn", di_exp(c[4:0], pb), fv);
            end
        end
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h0004_0201);
        cmd <= 8'h02;
        repeat (15) @(posedge aclk);
        cmd <= 8'h00;
        repeat (3) @(posedge aclk);
        cmd <= 8'h02;
        repeat (20) @(posedge aclk);
        chk("early", 0, fault_trip);
        repeat (10) @(posedge aclk);
        chk("trip", 1, fault_trip);
        cmd <= 8'h04;
        repeat (6) @(posedge aclk);
        chk("clear", 0, fault_trip);
        cmd <= 8'h00;
        wr(8'h00, 32'h0000_0301);
        repeat (30) @(posedge aclk);
        chk("low", 1, fault_trip);
        cmd <= 8'h01;
        repeat (6) @(posedge aclk);
        chk("stop", 1, stop_cmd);
        for (int c = 0; c <= 19; c++) begin
            pb = $urandom;
            st = $urandom;
            rb = $urandom;
            wr(8'h14, {26'h0, rb, pb, 1'b0});
            wr(8'h0c, {19'h0, c[4:0], 8'h01});
            starter_status <= st;
            fault_present <= st[15];
            repeat (4) @(posedge aclk);
            chk("relay", rl_exp(c[4:0], st, st[15], pb), relay_out[1]);
            chk("fs", !st[15], relay_out[0]);
            chk("bus", rb, relay_out[5:2]);
        end
        finish_test();
    end
endmodule

// file: iofm_field.sv
`timescale 1ns/10ps
// Field contacts feeding the terminals
module iofm_field (
    // Clock
    input wire logic aclk,
    // Contact commands
    input wire logic [7:0] contact_cmd,
    // Terminal levels, high is 120 V applied
    output logic [7:0] discrete_input
);
    // Contacts settle one edge after command
    always_ff @(posedge aclk) begin
        discrete_input <= contact_cmd;
    end
endmodule

// file: iofm_mapper.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module iofm_mapper #(
    parameter int N_DI = 8,
    parameter int N_RLY = 6,
    parameter int TENTH_CYCLES = iofm_pkg::TENTH_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Field inputs, high means 120 V applied
    input wire logic [N_DI-1:0] discrete_input,
    // Starter status
    input wire logic [iofm_pkg::ST_W-1:0] starter_status,
    input wire logic fault_present,
    // Function outputs
    output logic stop_cmd,
    output logic fault_trip,
    output logic disconnect_open,
    output logic inline_feedback,
    output logic bypass_feedback,
    output logic overload_clear,
    output logic remote_select,
    output logic heat_disable,
    output logic heat_enable,
    output logic ramp2_select,
    output logic slow_fwd_cmd,
    output logic slow_rev_cmd,
    output logic brake_disable,
    output logic brake_enable,
    output logic speed_switch,
    // Relay drives
    output logic [N_RLY-1:0] relay_out
);
    logic [31:0] di_cfg_lo_reg, di_cfg_hi_reg, rly_cfg_lo_reg, rly_cfg_hi_reg;
    logic [9:0] trip_time_reg;
    logic [N_RLY-1:0] rly_bus_reg;
    logic [N_DI-1:0] sync1_reg, sync2_reg;
    logic [N_DI-1:0] flt_hit;
    logic fault_latch_reg;
    logic fault_reset_any;
    logic [14:0] fn_next;
    logic [N_RLY-1:0] relay_next;
    logic [7:0] aw_addr_reg;
    logic aw_held_reg, w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic [4:0] di_sel [N_DI];
    logic [4:0] rl_sel [N_RLY];

    // Two-stage input synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= discrete_input;
            sync2_reg <= sync1_reg;
        end
    end

    // Configuration field extraction
    always_comb begin
        for (int i = 0; i < N_DI; i++) begin
            di_sel[i] = (i < 4) ? di_cfg_lo_reg[i*8 +: 5]
                                : di_cfg_hi_reg[(i-4)*8 +: 5];
        end
        for (int j = 0; j < N_RLY; j++) begin
            rl_sel[j] = (j < 4) ? rly_cfg_lo_reg[j*8 +: 5]
                                : rly_cfg_hi_reg[(j-4)*8 +: 5];
        end
    end

    // Per-input fault qualification timers
    genvar g;
    generate
        for (g = 0; g < N_DI; g++) begin : g_flt
            logic [$clog2(TENTH_CYCLES+1)-1:0] tick_reg;
            logic [9:0] tenth_reg;
            logic at_level;
            logic is_hi, is_lo;
            assign is_hi = di_sel[g] == 5'(iofm_pkg::IOFM_DI_FLT_HI);
            assign is_lo = di_sel[g] == 5'(iofm_pkg::IOFM_DI_FLT_LO);
            assign at_level = (is_hi && sync2_reg[g])
                || (is_lo && !sync2_reg[g]);
            assign flt_hit[g] = at_level && tenth_reg >= trip_time_reg;
            always_ff @(posedge aclk) begin
                if (!aresetn || !at_level) begin
                    tick_reg <= '0;
                    tenth_reg <= '0;
                end else if (tenth_reg < trip_time_reg) begin
                    if (tick_reg == ($bits(tick_reg))'(TENTH_CYCLES - 1)) begin
                        tick_reg <= '0;
                        tenth_reg <= tenth_reg + 10'h001;
                    end else begin
                        tick_reg <= tick_reg + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Fault latch, set wins over reset
    always_comb begin
        fault_reset_any = 1'b0;
        for (int i = 0; i < N_DI; i++) begin
            if (di_sel[i] == 5'(iofm_pkg::IOFM_DI_FLT_RST) && sync2_reg[i]) begin
                fault_reset_any = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_latch_reg <= 1'b0;
        end else if (|flt_hit) begin
            fault_latch_reg <= 1'b1;
        end else if (fault_reset_any) begin
            fault_latch_reg <= 1'b0;
        end
    end

    // Immediate input functions
    always_comb begin
        fn_next = '0;
        for (int i = 0; i < N_DI; i++) begin
            case (di_sel[i])
                5'(iofm_pkg::IOFM_DI_STOP): fn_next[0] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_DISC): fn_next[1] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_INLINE): fn_next[2] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_BYPASS): fn_next[3] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_OL_CLR): begin
                    fn_next[4] |= sync2_reg[i]
                        & starter_status[iofm_pkg::ST_OL_TRIP];
                end
                5'(iofm_pkg::IOFM_DI_LOCREM): fn_next[5] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_HEAT_DIS): fn_next[6] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_HEAT_EN): fn_next[7] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_RAMP): fn_next[8] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_SLOW_FWD): fn_next[9] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_SLOW_REV): fn_next[10] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_BRK_DIS): fn_next[11] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_BRK_EN): fn_next[12] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_SPD_NO): fn_next[13] |= sync2_reg[i];
                5'(iofm_pkg::IOFM_DI_SPD_NC): fn_next[13] |= !sync2_reg[i];
                default: ;
            endcase
        end
        fn_next[14] = fault_latch_reg;
    end

    // Registered function outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {fault_trip, brake_enable, brake_disable, slow_rev_cmd,
             slow_fwd_cmd, ramp2_select, heat_enable, heat_disable,
             remote_select, overload_clear, bypass_feedback,
             inline_feedback, disconnect_open, stop_cmd} <= '0;
            speed_switch <= 1'b0;
        end else begin
            stop_cmd <= fn_next[0];
            disconnect_open <= fn_next[1];
            inline_feedback <= fn_next[2];
            bypass_feedback <= fn_next[3];
            overload_clear <= fn_next[4];
            remote_select <= fn_next[5];
            heat_disable <= fn_next[6];
            heat_enable <= fn_next[7];
            ramp2_select <= fn_next[8];
            slow_fwd_cmd <= fn_next[9];
            slow_rev_cmd <= fn_next[10];
            brake_disable <= fn_next[11];
            brake_enable <= fn_next[12];
            speed_switch <= fn_next[13];
            fault_trip <= fn_next[14];
        end
    end

    // Relay selection
    always_comb begin
        for (int j = 0; j < N_RLY; j++) begin
            case (rl_sel[j])
                5'(iofm_pkg::IOFM_RL_OFF): relay_next[j] = rly_bus_reg[j];
                5'(iofm_pkg::IOFM_RL_FLT_FS): relay_next[j] = !fault_present;
                5'(iofm_pkg::IOFM_RL_FLT_NFS): relay_next[j] = fault_present;
                5'(iofm_pkg::IOFM_RL_RUN):
                    relay_next[j] = starter_status[iofm_pkg::ST_RUN];
                5'(iofm_pkg::IOFM_RL_UTS):
                    relay_next[j] = starter_status[iofm_pkg::ST_UTS];
                5'(iofm_pkg::IOFM_RL_ALARM):
                    relay_next[j] = starter_status[iofm_pkg::ST_ALARM];
                5'(iofm_pkg::IOFM_RL_READY):
                    relay_next[j] = starter_status[iofm_pkg::ST_READY];
                5'(iofm_pkg::IOFM_RL_LOCK):
                    relay_next[j] = starter_status[iofm_pkg::ST_LOCK];
                5'(iofm_pkg::IOFM_RL_OC):
                    relay_next[j] = starter_status[iofm_pkg::ST_OC];
                5'(iofm_pkg::IOFM_RL_UC):
                    relay_next[j] = starter_status[iofm_pkg::ST_UC];
                5'(iofm_pkg::IOFM_RL_OL_ALM):
                    relay_next[j] = starter_status[iofm_pkg::ST_OL_ALM];
                5'(iofm_pkg::IOFM_RL_SH_FS):
                    relay_next[j] = !starter_status[iofm_pkg::ST_SHUNT];
                5'(iofm_pkg::IOFM_RL_SH_NFS):
                    relay_next[j] = starter_status[iofm_pkg::ST_SHUNT];
                5'(iofm_pkg::IOFM_RL_GF):
                    relay_next[j] = starter_status[iofm_pkg::ST_GF];
                5'(iofm_pkg::IOFM_RL_ESAVE):
                    relay_next[j] = starter_status[iofm_pkg::ST_ESAVE];
                5'(iofm_pkg::IOFM_RL_HEAT):
                    relay_next[j] = starter_status[iofm_pkg::ST_HEAT];
                5'(iofm_pkg::IOFM_RL_SLOW):
                    relay_next[j] = starter_status[iofm_pkg::ST_SLOW_FWD]
                        | starter_status[iofm_pkg::ST_SLOW_REV];
                5'(iofm_pkg::IOFM_RL_SLOW_FWD):
                    relay_next[j] = starter_status[iofm_pkg::ST_SLOW_FWD];
                5'(iofm_pkg::IOFM_RL_SLOW_REV):
                    relay_next[j] = starter_status[iofm_pkg::ST_SLOW_REV];
                5'(iofm_pkg::IOFM_RL_BRAKE):
                    relay_next[j] = starter_status[iofm_pkg::ST_BRAKE];
                default: relay_next[j] = 1'b0;
            endcase
        end
    end

    // Relay drive flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relay_out <= '0;
        end else begin
            relay_out <= relay_next;
        end
    end

    // AXI write channel capture
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Ready flops follow the next held and response state
            s_axi_awready <= !wr_fire && !aw_held_reg
                && !(s_axi_awvalid && s_axi_awready)
                && !(s_axi_bvalid && !s_axi_bready);
            s_axi_wready <= !wr_fire && !w_held_reg
                && !(s_axi_wvalid && s_axi_wready)
                && !(s_axi_bvalid && !s_axi_bready);
        end
    end

    // Register writes, byte strobes on the four configuration registers only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            di_cfg_lo_reg <= iofm_pkg::DI_CFG_LO_RST;
            di_cfg_hi_reg <= iofm_pkg::DI_CFG_HI_RST;
            rly_cfg_lo_reg <= iofm_pkg::RLY_CFG_LO_RST;
            rly_cfg_hi_reg <= iofm_pkg::RLY_CFG_HI_RST;
            trip_time_reg <= iofm_pkg::TRIP_RST;
            rly_bus_reg <= '0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bresp <= 2'h0;
            for (int b = 0; b < 4; b++) begin
                if (w_strb_reg[b]) begin
                    case (aw_addr_reg)
                        iofm_pkg::DI_CFG_LO_OFS:
                            di_cfg_lo_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                        iofm_pkg::DI_CFG_HI_OFS:
                            di_cfg_hi_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                        iofm_pkg::RLY_CFG_LO_OFS:
                            rly_cfg_lo_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                        iofm_pkg::RLY_CFG_HI_OFS:
                            rly_cfg_hi_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                        default: ;
                    endcase
                end
            end
            case (aw_addr_reg)
                iofm_pkg::TRIP_TIME_OFS: begin
                    // Clamp into the settable range
                    if (w_data_reg[9:0] < iofm_pkg::TRIP_MIN) begin
                        trip_time_reg <= iofm_pkg::TRIP_MIN;
                    end else if (w_data_reg[9:0] > iofm_pkg::TRIP_MAX ||
                                 |w_data_reg[31:10]) begin
                        trip_time_reg <= iofm_pkg::TRIP_MAX;
                    end else begin
                        trip_time_reg <= w_data_reg[9:0];
                    end
                end
                iofm_pkg::RLY_BUS_OFS: rly_bus_reg <= w_data_reg[N_RLY-1:0];
                iofm_pkg::DI_CFG_LO_OFS, iofm_pkg::DI_CFG_HI_OFS,
                iofm_pkg::RLY_CFG_LO_OFS, iofm_pkg::RLY_CFG_HI_OFS: ;
                default: s_axi_bresp <= 2'h2;
            endcase
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                iofm_pkg::DI_CFG_LO_OFS: s_axi_rdata <= di_cfg_lo_reg;
                iofm_pkg::DI_CFG_HI_OFS: s_axi_rdata <= di_cfg_hi_reg;
                iofm_pkg::TRIP_TIME_OFS: s_axi_rdata <= {22'h0, trip_time_reg};
                iofm_pkg::RLY_CFG_LO_OFS: s_axi_rdata <= rly_cfg_lo_reg;
                iofm_pkg::RLY_CFG_HI_OFS: s_axi_rdata <= rly_cfg_hi_reg;
                iofm_pkg::RLY_BUS_OFS: s_axi_rdata <= 32'(rly_bus_reg);
                iofm_pkg::STATUS_OFS: s_axi_rdata <= 32'(starter_status);
                iofm_pkg::FUNC_OFS: s_axi_rdata <= 32'(fn_next);
                iofm_pkg::PIN_OFS:
                    s_axi_rdata <= {16'h0, 2'(0), relay_out, sync2_reg};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Address ready low while a read answer is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !(s_axi_arvalid && s_axi_arready)
                && !(s_axi_rvalid && !s_axi_rready);
        end
    end

    // Checks
    fault_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        |flt_hit |=> fault_latch_reg)
        else $error("fault not latched");
    fault_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_reset_any && !(|flt_hit) |=> !fault_latch_reg)
        else $error("fault reset ignored");
    trip_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
        trip_time_reg >= iofm_pkg::TRIP_MIN
        && trip_time_reg <= iofm_pkg::TRIP_MAX)
        else $error("trip time out of range");
    trip_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_latch_reg |=> fault_trip)
        else $error("trip output lags");
    hit_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flt_hit[0] |-> ((di_sel[0] == 5'(iofm_pkg::IOFM_DI_FLT_HI)
        && sync2_reg[0]) || (di_sel[0] == 5'(iofm_pkg::IOFM_DI_FLT_LO)
        && !sync2_reg[0])) && $past(g_flt[0].at_level))
        else $error("fault hit without level");
    relay_fs_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rl_sel[0] == 5'(iofm_pkg::IOFM_RL_FLT_FS) && $stable(rl_sel[0])
        |=> relay_out[0] == !$past(fault_present))
        else $error("fail-safe relay wrong");
    relay_nfs_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rl_sel[1] == 5'(iofm_pkg::IOFM_RL_FLT_NFS)
        |=> relay_out[1] == $past(fault_present))
        else $error("non-fail-safe relay wrong");
    stop_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
        di_sel[0] == 5'(iofm_pkg::IOFM_DI_STOP) && discrete_input[0]
        ##1 di_sel[0] == 5'(iofm_pkg::IOFM_DI_STOP)
        && discrete_input[0] ##1 di_sel[0] == 5'(iofm_pkg::IOFM_DI_STOP)
        |=> stop_cmd)
        else $error("stop not seen");
    cov_trip_c: cover property (@(posedge aclk) disable iff (!aresetn)
        !fault_latch_reg ##1 fault_latch_reg);
    cov_reset_c: cover property (@(posedge aclk) disable iff (!aresetn)
        fault_latch_reg ##1 !fault_latch_reg);
    cov_bus_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rl_sel[2] == 5'(iofm_pkg::IOFM_RL_OFF) && relay_out[2]);
endmodule

// file: iofm_pkg.sv
package iofm_pkg;
    // Register byte offsets
    localparam logic [7:0] DI_CFG_LO_OFS = 8'h00;   // Inputs 1..4, 8 bits each
    localparam logic [7:0] DI_CFG_HI_OFS = 8'h04;   // Inputs 5..8
    localparam logic [7:0] TRIP_TIME_OFS = 8'h08;   // Tenths of a second
    localparam logic [7:0] RLY_CFG_LO_OFS = 8'h0c;  // Relays 1..4
    localparam logic [7:0] RLY_CFG_HI_OFS = 8'h10;  // Relays 5..6
    localparam logic [7:0] RLY_BUS_OFS = 8'h14;     // Relay drive from serial link
    localparam logic [7:0] STATUS_OFS = 8'h18;      // Starter status inputs view
    localparam logic [7:0] FUNC_OFS = 8'h1c;        // Function outputs view
    localparam logic [7:0] PIN_OFS = 8'h20;         // Inputs and relays view

    // Input function codes
    typedef enum logic [4:0] {
        IOFM_DI_OFF = 5'h00, IOFM_DI_STOP = 5'h01, IOFM_DI_FLT_HI = 5'h02,
        IOFM_DI_FLT_LO = 5'h03, IOFM_DI_FLT_RST = 5'h04,
        IOFM_DI_DISC = 5'h05, IOFM_DI_INLINE = 5'h06, IOFM_DI_BYPASS = 5'h07,
        IOFM_DI_OL_CLR = 5'h08, IOFM_DI_LOCREM = 5'h09,
        IOFM_DI_HEAT_DIS = 5'h0a, IOFM_DI_HEAT_EN = 5'h0b,
        IOFM_DI_RAMP = 5'h0c, IOFM_DI_SLOW_FWD = 5'h0d,
        IOFM_DI_SLOW_REV = 5'h0e, IOFM_DI_BRK_DIS = 5'h0f,
        IOFM_DI_BRK_EN = 5'h10, IOFM_DI_SPD_NO = 5'h11,
        IOFM_DI_SPD_NC = 5'h12
    } iofm_di_fn_t;

    // Relay function codes
    typedef enum logic [4:0] {
        IOFM_RL_OFF = 5'h00, IOFM_RL_FLT_FS = 5'h01, IOFM_RL_FLT_NFS = 5'h02,
        IOFM_RL_RUN = 5'h03, IOFM_RL_UTS = 5'h04, IOFM_RL_ALARM = 5'h05,
        IOFM_RL_READY = 5'h06, IOFM_RL_LOCK = 5'h07, IOFM_RL_OC = 5'h08,
        IOFM_RL_UC = 5'h09, IOFM_RL_OL_ALM = 5'h0a, IOFM_RL_SH_FS = 5'h0b,
        IOFM_RL_SH_NFS = 5'h0c, IOFM_RL_GF = 5'h0d, IOFM_RL_ESAVE = 5'h0e,
        IOFM_RL_HEAT = 5'h0f, IOFM_RL_SLOW = 5'h10, IOFM_RL_SLOW_FWD = 5'h11,
        IOFM_RL_SLOW_REV = 5'h12, IOFM_RL_BRAKE = 5'h13
    } iofm_rl_fn_t;

    // Status vector bit positions
    localparam int ST_RUN = 0;
    localparam int ST_UTS = 1;
    localparam int ST_ALARM = 2;
    localparam int ST_READY = 3;
    localparam int ST_LOCK = 4;
    localparam int ST_OC = 5;
    localparam int ST_UC = 6;
    localparam int ST_OL_ALM = 7;
    localparam int ST_SHUNT = 8;
    localparam int ST_GF = 9;
    localparam int ST_ESAVE = 10;
    localparam int ST_HEAT = 11;
    localparam int ST_SLOW_FWD = 12;
    localparam int ST_SLOW_REV = 13;
    localparam int ST_BRAKE = 14;
    localparam int ST_OL_TRIP = 15;
    localparam int ST_W = 16;

    // Reset values
    localparam logic [31:0] DI_CFG_LO_RST = 32'h0000_0001;   // Input 1 stop
    localparam logic [31:0] DI_CFG_HI_RST = 32'h0000_0000;
    localparam logic [31:0] RLY_CFG_LO_RST = 32'h0000_0001;  // Relay 1 fault_failsafe_relay
    localparam logic [31:0] RLY_CFG_HI_RST = 32'h0000_0000;
    localparam logic [9:0] TRIP_MIN = 10'h001;    // 0.1 s
    localparam logic [9:0] TRIP_MAX = 10'h384;    // 90.0 s
    localparam logic [9:0] TRIP_RST = 10'h001;    // 0.1 s

    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int TENTH_S_MS = 100;
    localparam int TENTH_CYC = CLK_HZ / 1000 * TENTH_S_MS;
endpackage
